/* File: touch_burst_pkg.sv */
// constants and state types for the touch burst detection core
// Notes on behaviour
// [R1] short conversion bursts, idle in between
// [R2] fourteen-bit converter, started and done handshake
// [R3] output only after four consecutive detections
// [R4] 4 kHz differential tone for 75 ms
// [R5] three gain levels from the gain strap
// [R6] gain changes only the detection threshold
// [R7] board ties strap to a pin or open
// [R8] pulse mode sends state as output pulses
// [R9] periodic health blip; host keeps watching
// [R10] counter clears on any non-detecting burst
// [R11] bursts 95 ms apart, confirmations 2 ms
// [R12] straps sampled once after reset only
// [R13] detection means result exceeds reference by delta
package touch_burst_pkg;

   // clock and timing figures
   localparam int CLK_HZ           = 20_000_000;
   localparam int CLK_PER_US       = CLK_HZ / 1_000_000;
   localparam int BURST_SPACING_US = 95_000;
   localparam int FAST_SPACING_US  = 2_000;
   localparam int TONE_MS          = 75;
   localparam int TONE_HZ          = 4_000;
   localparam int BLIP_US          = 50;
   localparam int SLOW_CYC         = BURST_SPACING_US * CLK_PER_US;
   localparam int FAST_CYC         = FAST_SPACING_US * CLK_PER_US;
   localparam int TONE_CYC         = TONE_MS * 1_000 * CLK_PER_US;
   localparam int TONE_HALF_CYC    = CLK_HZ / (2 * TONE_HZ);
   localparam int BLIP_CYC         = BLIP_US * CLK_PER_US;

   // widths and counts
   localparam int RESULT_W      = 14;
   localparam int WAIT_W        = 21;
   localparam int TONE_W        = 21;
   localparam int HALF_W        = 12;
   localparam int BLIP_W        = 10;
   localparam int CONFIRM_COUNT = 4;

   // threshold deltas above the reference, per gain level
   localparam logic [RESULT_W-1:0] DELTA_HIGH   = 14'h0006;
   localparam logic [RESULT_W-1:0] DELTA_MEDIUM = 14'h000c;
   localparam logic [RESULT_W-1:0] DELTA_LOW    = 14'h0018;

   typedef enum logic [1:0] {
      GAIN_HIGH   = 2'h0,
      GAIN_MEDIUM = 2'h1,
      GAIN_LOW    = 2'h2
   } gain_t;

   // burst sequencer, gray coded around the loop
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_START = 2'h1,
      ST_WAIT  = 2'h3,
      ST_EVAL  = 2'h2
   } burst_state_t;

   typedef struct packed {
      burst_state_t          state;
      logic [WAIT_W-1:0]     wait_cnt;
      logic [2:0]            cnt;
      logic                  detect;
      logic [RESULT_W-1:0]   result;
      logic [RESULT_W-1:0]   ref_level;
      logic                  ref_valid;
      gain_t                 gain;
      logic                  pulse_mode;
      logic                  straps_taken;
      logic [BLIP_W-1:0]     blip_cnt;
      logic                  out;
      logic                  tone_go;
   } core_state_t;

   typedef struct packed {
      logic                  busy;
      logic [TONE_W-1:0]     dur_cnt;
      logic [HALF_W-1:0]     half_cnt;
      logic                  phase;
   } tone_state_t;

endpackage

/* File: tone_drive.sv */
// differential square-wave driver for the piezo across both sense pins
`timescale 1ns/100ps
module tone_drive #(
   parameter int HALF_CYC = touch_burst_pkg::TONE_HALF_CYC,
   parameter int DUR_CYC  = touch_burst_pkg::TONE_CYC
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_srst,
   // start request
   input  wire logic i_go,
   // pin drive
   output logic      o_pin_a,
   output logic      o_pin_b,
   output logic      o_oe,
   output logic      o_busy
);

   touch_burst_pkg::tone_state_t st;
   touch_burst_pkg::tone_state_t next_st;

   // duration and half-period counters
   always_comb begin
      next_st = st;
      if (!st.busy) begin
         if (i_go) begin
            next_st.busy     = 1'b1;
            next_st.dur_cnt  = touch_burst_pkg::TONE_W'(DUR_CYC - 1);
            next_st.half_cnt = touch_burst_pkg::HALF_W'(HALF_CYC - 1);
            next_st.phase    = 1'b0;
         end
      end else if (st.dur_cnt == '0) begin
         next_st.busy = 1'b0;
      end else begin
         next_st.dur_cnt = st.dur_cnt - 1'b1;
         if (st.half_cnt == '0) begin
            next_st.half_cnt = touch_burst_pkg::HALF_W'(HALF_CYC - 1);
            next_st.phase    = ~st.phase;
         end else begin
            next_st.half_cnt = st.half_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // [R4] pins in antiphase
   assign o_pin_a = st.busy & st.phase;
   assign o_pin_b = st.busy & ~st.phase;
   assign o_oe    = st.busy;
   assign o_busy  = st.busy;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   property p_tone_antiphase;
      o_oe |-> (o_pin_a != o_pin_b);
   endproperty
   a_tone_antiphase: assert property (p_tone_antiphase) else $error("tone pins not in antiphase"); // [R4]

endmodule

/* File: touch_burst_detect_core.sv */
// burst sequencer, consensus filter, strap capture and output line
`timescale 1ns/100ps
module touch_burst_detect_core #(
   parameter int SLOW_CYC = touch_burst_pkg::SLOW_CYC,
   parameter int FAST_CYC = touch_burst_pkg::FAST_CYC,
   parameter int TONE_CYC = touch_burst_pkg::TONE_CYC,
   parameter int BLIP_CYC = touch_burst_pkg::BLIP_CYC
) (
   // clock and reset
   input  wire logic                                 i_core_clk,
   input  wire logic                                 i_srst,
   // converter handshake
   output logic                                      o_conv_start,
   input  wire logic                                 i_conv_done,
   input  wire logic [touch_burst_pkg::RESULT_W-1:0] i_conv_result,
   // straps
   input  wire logic                                 i_gain_to_pin_a,
   input  wire logic                                 i_gain_to_pin_b,
   input  wire logic                                 i_option_strap_first,
   // sense pin tone drive
   output logic                                      o_sense_pin_a_out,
   output logic                                      o_sense_pin_a_oe,
   output logic                                      o_sense_pin_b_out,
   output logic                                      o_sense_pin_b_oe,
   // detection output line
   output logic                                      o_out,
   output logic                                      o_detect
);

   touch_burst_pkg::core_state_t st;
   touch_burst_pkg::core_state_t next_st;

   logic                                 tone_busy;
   logic                                 tone_oe;
   logic [touch_burst_pkg::RESULT_W-1:0] delta;
   logic [touch_burst_pkg::RESULT_W:0]   thresh;
   logic                                 hit;
   logic                                 changed;
   logic                                 load_blip;

   // [R6] gain picks only the threshold delta
   always_comb begin
      case (st.gain)
         touch_burst_pkg::GAIN_HIGH:   delta = touch_burst_pkg::DELTA_HIGH;
         touch_burst_pkg::GAIN_MEDIUM: delta = touch_burst_pkg::DELTA_MEDIUM;
         touch_burst_pkg::GAIN_LOW:    delta = touch_burst_pkg::DELTA_LOW;
         default:                      delta = touch_burst_pkg::DELTA_HIGH;
      endcase
   end

   // [R13] detection against reference plus delta
   assign thresh = {1'b0, st.ref_level} + {1'b0, delta};
   assign hit    = st.ref_valid && ({1'b0, st.result} >= thresh);

   // next-state logic for the whole core
   always_comb begin
      next_st         = st;
      next_st.tone_go = 1'b0;
      changed         = 1'b0;
      load_blip       = 1'b0;

      // [R12] straps caught once, first cycle after reset
      if (!st.straps_taken) begin
         next_st.straps_taken = 1'b1;
         next_st.pulse_mode   = i_option_strap_first;
         // [R5] open, pin a or pin b
         if (i_gain_to_pin_a) begin
            next_st.gain = touch_burst_pkg::GAIN_MEDIUM;
         end else if (i_gain_to_pin_b) begin
            next_st.gain = touch_burst_pkg::GAIN_LOW;
         end else begin
            next_st.gain = touch_burst_pkg::GAIN_HIGH;
         end
      end

      if (st.blip_cnt != '0) begin
         next_st.blip_cnt = st.blip_cnt - 1'b1;
      end

      case (st.state)
         // [R1] idle spacing between bursts
         touch_burst_pkg::ST_IDLE: begin
            if (st.wait_cnt != '0) begin
               next_st.wait_cnt = st.wait_cnt - 1'b1;
            end else if (!tone_busy && st.straps_taken) begin
               // the converter shares the pins with the tone
               next_st.state = touch_burst_pkg::ST_START;
            end
         end
         // [R2] one-cycle start, then wait for done
         touch_burst_pkg::ST_START: begin
            next_st.state = touch_burst_pkg::ST_WAIT;
         end
         touch_burst_pkg::ST_WAIT: begin
            if (i_conv_done) begin
               next_st.result = i_conv_result;
               next_st.state  = touch_burst_pkg::ST_EVAL;
            end
         end
         touch_burst_pkg::ST_EVAL: begin
            next_st.state    = touch_burst_pkg::ST_IDLE;
            next_st.wait_cnt = touch_burst_pkg::WAIT_W'(SLOW_CYC - 1);
            if (!st.ref_valid) begin
               // first burst after reset is the calibration
               next_st.ref_level = st.result;
               next_st.ref_valid = 1'b1;
            end else if (hit) begin
               if (!st.detect) begin
                  // [R3] fourth consecutive hit asserts output
                  if (st.cnt == 3'(touch_burst_pkg::CONFIRM_COUNT - 1)) begin
                     next_st.detect  = 1'b1;
                     next_st.cnt     = '0;
                     next_st.tone_go = 1'b1;
                     changed         = 1'b1;
                  end else begin
                     next_st.cnt = st.cnt + 1'b1;
                     // [R11] confirmation bursts follow quickly
                     next_st.wait_cnt = touch_burst_pkg::WAIT_W'(FAST_CYC - 1);
                  end
               end
            end else begin
               // [R10] any miss clears the counter
               next_st.cnt = '0;
               if (st.detect) begin
                  next_st.detect = 1'b0;
                  changed        = 1'b1;
               end
            end
            // [R9] health blip after every burst that leaves the counter at zero, except a dc-mode burst that changes the output
            load_blip = changed ? st.pulse_mode : (next_st.cnt == '0);
            if (load_blip) begin
               next_st.blip_cnt = touch_burst_pkg::BLIP_W'(BLIP_CYC);
            end
         end
         default: begin
            next_st.state = touch_burst_pkg::ST_IDLE;
         end
      endcase

      // [R8] pulse mode carries only pulses, not a level
      if (st.pulse_mode) begin
         next_st.out = (next_st.blip_cnt != '0);
      end else begin
         next_st.out = next_st.detect ^ (next_st.blip_cnt != '0);
      end
   end

   // one register for the whole state
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // [R4] tone starts with the detection
   tone_drive #(
      .HALF_CYC (touch_burst_pkg::TONE_HALF_CYC),
      .DUR_CYC  (TONE_CYC)
   ) u_tone (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_go       (st.tone_go),
      .o_pin_a    (o_sense_pin_a_out),
      .o_pin_b    (o_sense_pin_b_out),
      .o_oe       (tone_oe),
      .o_busy     (tone_busy)
   );

   // outputs
   assign o_sense_pin_a_oe = tone_oe;
   assign o_sense_pin_b_oe = tone_oe;
   assign o_conv_start     = (st.state == touch_burst_pkg::ST_START);
   assign o_out            = st.out;
   assign o_detect         = st.detect;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   sequence s_burst;
      o_conv_start ##1 (st.state == touch_burst_pkg::ST_WAIT);
   endsequence

   sequence s_last_hit;
      (st.state == touch_burst_pkg::ST_EVAL) && hit && !st.detect && (st.cnt == 3'h3);
   endsequence

   property p_start_pulse;
      o_conv_start |-> s_burst ##0 !o_conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start not a single pulse"); // [R2]

   property p_idle_quiet;
      (st.state == touch_burst_pkg::ST_IDLE) && (st.wait_cnt > 21'h000001) |=> !o_conv_start;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("burst started during spacing"); // [R1]

   property p_confirm;
      $rose(o_detect) |-> $past(st.cnt) == 3'h3 && $past(hit);
   endproperty
   a_confirm: assert property (p_confirm) else $error("output rose without four hits"); // [R3]

   property p_tone_follows;
      s_last_hit |=> st.tone_go ##1 tone_busy ##1 tone_oe;
   endproperty
   a_tone_follows: assert property (p_tone_follows) else $error("tone did not follow detection"); // [R4]

   property p_miss_clears;
      (st.state == touch_burst_pkg::ST_EVAL) && st.ref_valid && !hit |=> st.cnt == 3'h0;
   endproperty
   a_miss_clears: assert property (p_miss_clears) else $error("counter not cleared on miss"); // [R10]

   property p_fast_spacing;
      (st.state == touch_burst_pkg::ST_EVAL) && hit && !st.detect && (st.cnt < 3'h3)
         |=> st.wait_cnt == touch_burst_pkg::WAIT_W'(FAST_CYC - 1);
   endproperty
   a_fast_spacing: assert property (p_fast_spacing) else $error("confirmation spacing wrong"); // [R11]

   property p_strap_hold;
      st.straps_taken |=> $stable(st.gain) && $stable(st.pulse_mode);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap value changed after capture"); // [R12]

   property p_below_ref;
      (st.state == touch_burst_pkg::ST_EVAL) && st.ref_valid && (st.result < st.ref_level)
         |=> st.cnt == 3'h0 && !o_detect;
   endproperty
   a_below_ref: assert property (p_below_ref) else $error("detection below reference"); // [R13]

   // dc mode: a falling output carries no blip, so the level edge stays clean
   property p_health;
      (st.state == touch_burst_pkg::ST_EVAL) && !hit && (st.pulse_mode || !st.detect)
         |=> st.blip_cnt != '0;
   endproperty
   a_health: assert property (p_health) else $error("no health blip after burst"); // [R9]

   property p_pulse_mode;
      st.pulse_mode && (st.blip_cnt == '0) |-> !o_out;
   endproperty
   a_pulse_mode: assert property (p_pulse_mode) else $error("level on output in pulse mode"); // [R8]

   property p_gain_delta;
      (st.gain == touch_burst_pkg::GAIN_LOW) |-> delta > touch_burst_pkg::DELTA_MEDIUM;
   endproperty
   a_gain_delta: assert property (p_gain_delta) else $error("low gain threshold not largest"); // [R6]

endmodule

/* File: touch_host_model.sv */
// far-side model: converter answer plus host watching the output line
`timescale 1ns/100ps
module touch_host_model (
   // clock and reset
   input  wire logic                                 i_core_clk,
   input  wire logic                                 i_srst,
   // converter side
   input  wire logic                                 i_conv_start,
   input  wire logic                                 i_slow,
   input  wire logic [touch_burst_pkg::RESULT_W-1:0] i_level,
   output logic                                      o_conv_done,
   output logic [touch_burst_pkg::RESULT_W-1:0]      o_conv_result,
   // output line watch
   input  wire logic                                 i_line,
   output int                                        o_blips
);
   int   wait_cnt;
   logic line_q;

   // one result per start
   // stale result bus flips every cycle so a late sample never matches
   always @(posedge i_core_clk) begin
      o_conv_done   <= 1'b0;
      o_conv_result <= i_srst ? '0 : ~o_conv_result;
      if (i_srst) begin
         wait_cnt <= 0;
      end else if (i_conv_start) begin
         wait_cnt <= i_slow ? 30 : 1;
      end else if (wait_cnt == 1) begin
         o_conv_done   <= 1'b1;
         o_conv_result <= i_level;
         wait_cnt      <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end

   always @(posedge i_core_clk) begin
      line_q <= i_line;
      if (i_srst) begin
         o_blips <= 0;
      end else if (i_line && !line_q) begin
         o_blips <= o_blips + 1;
      end
   end
endmodule

/* File: touch_burst_detect_core_tb.sv */
// self-checking bench for the touch burst detection core
`timescale 1ns/100ps
module touch_burst_detect_core_tb;
   localparam int SLOW = 200;
   localparam int FAST = 50;
   localparam logic [13:0] REF = 14'h0400;

   logic        clk;
   logic        srst;
   logic        start;
   logic        done;
   logic        to_a;
   logic        to_b;
   logic        option_strap_first;
   logic        slow;
   logic [13:0] res;
   logic [13:0] level;
   logic        pa;
   logic        pa_oe;
   logic        pb;
   logic        pb_oe;
   logic        line;
   logic        det;
   int          blips;
   int          n_mismatch;
   int          n_compared;
   int          gap;

   touch_burst_detect_core #(
      .SLOW_CYC (SLOW),
      .FAST_CYC (FAST),
      .TONE_CYC (100),
      .BLIP_CYC (5)
   ) uut (
      .i_core_clk           (clk),
      .i_srst               (srst),
      .o_conv_start         (start),
      .i_conv_done          (done),
      .i_conv_result        (res),
      .i_gain_to_pin_a      (to_a),
      .i_gain_to_pin_b      (to_b),
      .i_option_strap_first (option_strap_first),
      .o_sense_pin_a_out    (pa),
      .o_sense_pin_a_oe     (pa_oe),
      .o_sense_pin_b_out    (pb),
      .o_sense_pin_b_oe     (pb_oe),
      .o_out                (line),
      .o_detect             (det)
   );

   touch_host_model host (
      .i_core_clk    (clk),
      .i_srst        (srst),
      .i_conv_start  (start),
      .i_slow        (slow),
      .i_level       (level),
      .o_conv_done   (done),
      .o_conv_result (res),
      .i_line        (line),
      .o_blips       (blips)
   );

   // 20 MHz core clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic restart(input logic a, input logic b, input logic p);
      @(posedge clk);
      #5;
      srst = 1'b1;
      to_a = a;
      to_b = b;
      option_strap_first = p;
      repeat (5) @(posedge clk);
      #5;
      srst = 1'b0;
   endtask

   // one burst: wait for start under a bound, then let the answer settle
   task automatic burst(input logic [13:0] v);
      int n;
      level = v;
      n = 0;
      while (start !== 1'b1) begin
         @(posedge clk);
         #5;
         n++;
         if (n > 3000) begin
            n_mismatch++;
            complete_run();
         end
      end
      @(posedge clk);
      #5;
      check(start, 1'b0);
      repeat (39) @(posedge clk);
      #5;
      gap = n + 40;
   endtask

   // threshold per gain, consensus count, spacing, tone, strap capture
   task automatic gain_case(input logic a, input logic b, input logic [13:0] d);
      int b0;
      restart(a, b, 1'b0);
      burst(REF);
      // later strap change, still a legal single tie, must be ignored
      to_a = ~a;
      to_b = a;
      burst(REF + d - 14'h0001);
      check(det, 1'b0);
      check(gap >= SLOW, 1'b1);
      repeat (3) burst(REF + d);
      check(det, 1'b0);
      check(gap < SLOW, 1'b1);
      // a result below the reference is a miss and still blips
      b0 = blips;
      burst(REF - 14'h0001);
      check(blips > b0, 1'b1);
      repeat (3) burst(REF + d);
      check(det, 1'b0);
      burst(REF + d);
      check(gap < SLOW, 1'b1);
      check(det, 1'b1);
      check(line, 1'b1);
      check({pa_oe, pb_oe}, 2'b11);
      check(pa ^ pb, 1'b1);
      repeat (120) @(posedge clk);
      #5;
      check({pa_oe, pb_oe}, 2'b00);
      burst(REF);
      check(det, 1'b0);
   endtask

   // pulse output mode with a slow converter
   task automatic pulse_case();
      int b0;
      slow = 1'b1;
      restart(1'b0, 1'b0, 1'b1);
      burst(REF);
      repeat (3) burst(REF + touch_burst_pkg::DELTA_HIGH);
      b0 = blips;
      burst(REF + touch_burst_pkg::DELTA_HIGH);
      check(det, 1'b1);
      check(line, 1'b0);
      check(blips > b0, 1'b1);
      repeat (2) burst(REF);
      b0 = blips;
      burst(REF);
      check(blips > b0, 1'b1);
      check(det, 1'b0);
   endtask

   initial begin
      srst = 1'b1;
      to_a = 1'b0;
      to_b = 1'b0;
      option_strap_first = 1'b0;
      slow = 1'b0;
      level = '0;
      n_mismatch = 0;
      n_compared = 0;
      gap = 0;
      gain_case(1'b0, 1'b0, touch_burst_pkg::DELTA_HIGH);
      gain_case(1'b1, 1'b0, touch_burst_pkg::DELTA_MEDIUM);
      gain_case(1'b0, 1'b1, touch_burst_pkg::DELTA_LOW);
      pulse_case();
      complete_run();
   end
endmodule
